// [src/fdsq_seq.v]
// Purpose: sector read/write sequencer behind an apb register file
// Assumes: a data separator gives byte strobes and mark detects
// Notes: every apb access takes one wait state
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`include "fdsq_defines.vh"
module fdsq_seq #(
    parameter [23:0] SETTLE_CYCLES = `FDSQ_SETTLE_MS * `FDSQ_CLK_KHZ
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // disk read side
    input wire disk_byte_stb,
    input wire [7:0] disk_byte_in,
    input wire id_mark_in,
    input wire data_mark_in,
    input wire deleted_mark_in,
    input wire index_in,
    input wire head_engaged_in,
    // drive control and write side
    output reg head_load_out,
    output reg side_select_out,
    output reg write_gate_out,
    output reg [7:0] write_byte_out,
    output reg write_missing_clock_out,
    // host signalling
    output reg byte_request,
    output reg irq_out
);

// ----------------------------------------
// states
// ----------------------------------------
localparam S_IDLE = 14'h0001;
localparam S_SETTLE = 14'h0002;
localparam S_ENGAGE = 14'h0004;
localparam S_SEARCH = 14'h0008;
localparam S_IDRD = 14'h0010;
localparam S_DAMW = 14'h0020;
localparam S_RDATA = 14'h0040;
localparam S_RCRC = 14'h0080;
localparam S_WGAP = 14'h0100;
localparam S_WZERO = 14'h0200;
localparam S_WSYNC = 14'h0400;
localparam S_WDATA = 14'h0800;
localparam S_WCRC = 14'h1000;
localparam S_WFF = 14'h2000;

// ----------------------------------------
// functions
// ----------------------------------------
function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] b;
    integer i;
    reg [15:0] t;
    begin
        t = c;
        for (i = 7; i >= 0; i = i - 1) begin
            if (t[15] ^ b[i]) begin
                t = {t[14:0], 1'b0} ^ `FDSQ_CRC_POLY;
            end else begin
                t = {t[14:0], 1'b0};
            end
        end
        crc_byte = t;
    end
endfunction

// crc state just after a mark, sync bytes included in double density
function [15:0] crc_mark;
    input dd;
    input [7:0] m;
    reg [15:0] t;
    begin
        t = `FDSQ_CRC_INIT;
        if (dd) begin
            t = crc_byte(t, `FDSQ_B_SYNC);
            t = crc_byte(t, `FDSQ_B_SYNC);
            t = crc_byte(t, `FDSQ_B_SYNC);
        end
        crc_mark = crc_byte(t, m);
    end
endfunction

function [10:0] sect_len;
    input flag;
    input [1:0] code;
    begin
        if (flag) begin
            sect_len = `FDSQ_LEN_BASE << code;
        end else begin
            sect_len = `FDSQ_LEN_ALT << code;
            if (sect_len == `FDSQ_CNT_ZERO) begin
                sect_len = `FDSQ_LEN_BASE;
            end
        end
    end
endfunction

function reg_hit;
    input [7:0] a;
    begin
        reg_hit = (a == `FDSQ_A_CMD) || (a == `FDSQ_A_TRK) ||
            (a == `FDSQ_A_SEC) || (a == `FDSQ_A_DATA) ||
            (a == `FDSQ_A_STAT) || (a == `FDSQ_A_SPT) ||
            (a == `FDSQ_A_ABORT);
    end
endfunction

// ----------------------------------------
// registers and decode
// ----------------------------------------
reg [13:0] state_reg;
reg [7:0] cmd_reg;
reg [7:0] track_reg;
reg [7:0] sector_reg;
reg [7:0] spt_reg;
reg [7:0] data_reg;
reg busy_reg;
reg lost_reg;
reg rnf_reg;
reg crcerr_reg;
reg del_reg;
reg [23:0] timer_reg;
reg [10:0] cnt_reg;
reg [10:0] len_reg;
reg [3:0] idx_reg;
reg [15:0] crc_reg;
reg [7:0] id_trk;
reg [7:0] id_side;
reg [7:0] id_sec;
reg [31:0] rd_word;
reg [7:0] wr_byte;

wire apb_done = psel && penable && pready;
wire wr_cmd = apb_done && pwrite && (paddr == `FDSQ_A_CMD);
wire wr_trk = apb_done && pwrite && (paddr == `FDSQ_A_TRK);
wire wr_sec = apb_done && pwrite && (paddr == `FDSQ_A_SEC);
wire wr_data = apb_done && pwrite && (paddr == `FDSQ_A_DATA);
wire wr_spt = apb_done && pwrite && (paddr == `FDSQ_A_SPT);
wire wr_abort = apb_done && pwrite && (paddr == `FDSQ_A_ABORT);
wire rd_data = apb_done && !pwrite && (paddr == `FDSQ_A_DATA);
wire rd_stat = apb_done && !pwrite && (paddr == `FDSQ_A_STAT);
wire dd = cmd_reg[`FDSQ_C_DDEN];
wire [10:0] gap_n = dd ? `FDSQ_GAP_DD : `FDSQ_GAP_SD;
wire [10:0] zero_n = dd ? `FDSQ_ZERO_DD : `FDSQ_ZERO_SD;
wire [10:0] dam_n = dd ? `FDSQ_DAM_DD : `FDSQ_DAM_SD;
wire [3:0] rev_n = cmd_reg[`FDSQ_C_SCMP] ? `FDSQ_REVS_SIDE : `FDSQ_REVS_ID;
wire [7:0] mark_b = cmd_reg[`FDSQ_C_DEL] ? `FDSQ_B_DDAM : `FDSQ_B_DAM;
wire [15:0] crc_nx = crc_byte(crc_reg, disk_byte_in);
wire [10:0] cnt_nx = cnt_reg + `FDSQ_CNT_ONE;
wire side_ok = !cmd_reg[`FDSQ_C_SCMP] ||
    (id_side[0] == cmd_reg[`FDSQ_C_SIDE]);
// a host write landing in the same cycle still counts as serviced
wire svc = !byte_request || wr_data;

always @* begin
    wr_byte = data_reg;
    if (byte_request) begin
        wr_byte = wr_data ? pwdata[7:0] : `FDSQ_B_ZERO;
    end
end

always @* begin
    rd_word = 32'h00000000;
    case (paddr)
        `FDSQ_A_CMD: rd_word[7:0] = cmd_reg;
        `FDSQ_A_TRK: rd_word[7:0] = track_reg;
        `FDSQ_A_SEC: rd_word[7:0] = sector_reg;
        `FDSQ_A_DATA: rd_word[7:0] = data_reg;
        `FDSQ_A_SPT: rd_word[7:0] = spt_reg;
        `FDSQ_A_STAT: begin
            rd_word[`FDSQ_S_BUSY] = busy_reg;
            rd_word[`FDSQ_S_DRQ] = byte_request;
            rd_word[`FDSQ_S_LOST] = lost_reg;
            rd_word[`FDSQ_S_RNF] = rnf_reg;
            rd_word[`FDSQ_S_CRC] = crcerr_reg;
            rd_word[`FDSQ_S_DEL] = del_reg;
        end
        default: rd_word = 32'h00000000;
    endcase
end

// ----------------------------------------
// apb answer
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
        pready <= 1'b1;
        pslverr <= !reg_hit(paddr);
        prdata <= rd_word;
    end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
end

// ----------------------------------------
// sequencer tasks
// ----------------------------------------
task end_cmd;
    begin
        busy_reg <= 1'b0;
        irq_out <= 1'b1;
        byte_request <= 1'b0;
        write_gate_out <= 1'b0;
        write_missing_clock_out <= 1'b0;
        idx_reg <= 4'h0;
        state_reg <= S_IDLE;
    end
endtask

task sec_done;
    begin
        if (cmd_reg[`FDSQ_C_MULTI]) begin
            sector_reg <= sector_reg + 8'h01;
            if (sector_reg >= spt_reg) begin
                rnf_reg <= 1'b1;
                end_cmd;
            end else begin
                idx_reg <= 4'h0;
                cnt_reg <= `FDSQ_CNT_ZERO;
                state_reg <= S_SEARCH;
            end
        end else begin
            end_cmd;
        end
    end
endtask

// data mark leads the data field; single density has no sync bytes
task emit_mark;
    begin
        write_byte_out <= mark_b;
        write_missing_clock_out <= 1'b1;
        crc_reg <= crc_mark(dd, mark_b);
        cnt_reg <= `FDSQ_CNT_ZERO;
        state_reg <= S_WDATA;
    end
endtask

// ----------------------------------------
// sequencer
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_reg <= S_IDLE;
        cmd_reg <= 8'h00;
        track_reg <= 8'h00;
        sector_reg <= 8'h00;
        spt_reg <= 8'h00;
        data_reg <= 8'h00;
        busy_reg <= 1'b0;
        lost_reg <= 1'b0;
        rnf_reg <= 1'b0;
        crcerr_reg <= 1'b0;
        del_reg <= 1'b0;
        timer_reg <= 24'h000000;
        cnt_reg <= 11'h000;
        len_reg <= 11'h000;
        idx_reg <= 4'h0;
        crc_reg <= 16'h0000;
        id_trk <= 8'h00;
        id_side <= 8'h00;
        id_sec <= 8'h00;
        head_load_out <= 1'b0;
        side_select_out <= 1'b0;
        write_gate_out <= 1'b0;
        write_byte_out <= 8'h00;
        write_missing_clock_out <= 1'b0;
        byte_request <= 1'b0;
        irq_out <= 1'b0;
    end else begin
        // host writes first so device events below win the same cycle
        if (wr_trk) begin
            track_reg <= pwdata[7:0];
        end
        if (wr_spt) begin
            spt_reg <= pwdata[7:0];
        end
        if (wr_sec && !busy_reg) begin
            sector_reg <= pwdata[7:0];
        end
        if (wr_data) begin
            data_reg <= pwdata[7:0];
            byte_request <= 1'b0;
        end
        if (rd_data) begin
            byte_request <= 1'b0;
        end
        if (rd_stat || wr_cmd) begin
            irq_out <= 1'b0;
        end
        case (state_reg)
            S_IDLE: begin
                if (wr_cmd) begin
                    cmd_reg <= pwdata[7:0];
                    busy_reg <= 1'b1;
                    lost_reg <= 1'b0;
                    rnf_reg <= 1'b0;
                    crcerr_reg <= 1'b0;
                    del_reg <= 1'b0;
                    byte_request <= 1'b0;
                    idx_reg <= 4'h0;
                    head_load_out <= 1'b1;
                    side_select_out <= pwdata[`FDSQ_C_SIDE];
                    timer_reg <= SETTLE_CYCLES;
                    if (pwdata[`FDSQ_C_SETTLE]) begin
                        state_reg <= S_SETTLE;
                    end else begin
                        state_reg <= S_ENGAGE;
                    end
                end else if (index_in && head_load_out) begin
                    // idle head unloads after fifteen index pulses
                    if (idx_reg == `FDSQ_IDLE_IDX - 4'h1) begin
                        head_load_out <= 1'b0;
                        idx_reg <= 4'h0;
                    end else begin
                        idx_reg <= idx_reg + 4'h1;
                    end
                end
            end
            S_SETTLE: begin
                if (timer_reg <= 24'h000001) begin
                    state_reg <= S_ENGAGE;
                end else begin
                    timer_reg <= timer_reg - 24'h000001;
                end
            end
            S_ENGAGE: begin
                if (head_engaged_in) begin
                    state_reg <= S_SEARCH;
                end
            end
            S_SEARCH: begin
                if (index_in) begin
                    if (idx_reg + 4'h1 >= rev_n) begin
                        rnf_reg <= 1'b1;
                        end_cmd;
                    end else begin
                        idx_reg <= idx_reg + 4'h1;
                    end
                end else if (id_mark_in) begin
                    crc_reg <= crc_mark(dd, `FDSQ_B_ID_ADDRESS_MARK);
                    cnt_reg <= `FDSQ_CNT_ZERO;
                    state_reg <= S_IDRD;
                end
            end
            S_IDRD: begin
                if (disk_byte_stb) begin
                    crc_reg <= crc_nx;
                    cnt_reg <= cnt_nx;
                    case (cnt_reg[2:0])
                        `FDSQ_ID_TRK: id_trk <= disk_byte_in;
                        `FDSQ_ID_SIDE: id_side <= disk_byte_in;
                        `FDSQ_ID_SEC: id_sec <= disk_byte_in;
                        `FDSQ_ID_LEN: len_reg <= sect_len(cmd_reg[`FDSQ_C_SIZE],
                            disk_byte_in[1:0]);
                        default: id_trk <= id_trk;
                    endcase
                    if (cnt_reg == `FDSQ_ID_LAST) begin
                        cnt_reg <= `FDSQ_CNT_ZERO;
                        if (crc_nx == `FDSQ_CRC_GOOD && id_trk == track_reg &&
                            id_sec == sector_reg && side_ok) begin
                            if (cmd_reg[`FDSQ_C_WRITE]) begin
                                byte_request <= 1'b1;
                                state_reg <= S_WGAP;
                            end else begin
                                state_reg <= S_DAMW;
                            end
                        end else begin
                            state_reg <= S_SEARCH;
                        end
                    end
                end
            end
            S_DAMW: begin
                if (data_mark_in) begin
                    del_reg <= deleted_mark_in;
                    crc_reg <= crc_mark(dd, deleted_mark_in ?
                        `FDSQ_B_DDAM : `FDSQ_B_DAM);
                    cnt_reg <= `FDSQ_CNT_ZERO;
                    state_reg <= S_RDATA;
                end else if (disk_byte_stb) begin
                    if (cnt_nx >= dam_n) begin
                        rnf_reg <= 1'b1;
                        end_cmd;
                    end else begin
                        cnt_reg <= cnt_nx;
                    end
                end
            end
            S_RDATA: begin
                if (disk_byte_stb) begin
                    crc_reg <= crc_nx;
                    if (byte_request && !rd_data) begin
                        lost_reg <= 1'b1;
                    end else begin
                        data_reg <= disk_byte_in;
                        byte_request <= 1'b1;
                    end
                    if (cnt_nx == len_reg) begin
                        cnt_reg <= `FDSQ_CNT_ZERO;
                        state_reg <= S_RCRC;
                    end else begin
                        cnt_reg <= cnt_nx;
                    end
                end
            end
            S_RCRC: begin
                if (disk_byte_stb) begin
                    crc_reg <= crc_nx;
                    cnt_reg <= cnt_nx;
                    if (cnt_reg == `FDSQ_CNT_ONE) begin
                        if (crc_nx == `FDSQ_CRC_GOOD) begin
                            sec_done;
                        end else begin
                            crcerr_reg <= 1'b1;
                            end_cmd;
                        end
                    end
                end
            end
            S_WGAP: begin
                if (disk_byte_stb) begin
                    if (cnt_nx == gap_n) begin
                        if (!svc) begin
                            lost_reg <= 1'b1;
                            end_cmd;
                        end else begin
                            write_gate_out <= 1'b1;
                            write_byte_out <= `FDSQ_B_ZERO;
                            cnt_reg <= `FDSQ_CNT_ONE;
                            state_reg <= S_WZERO;
                        end
                    end else begin
                        cnt_reg <= cnt_nx;
                    end
                end
            end
            S_WZERO: begin
                if (disk_byte_stb) begin
                    if (cnt_reg != zero_n) begin
                        write_byte_out <= `FDSQ_B_ZERO;
                        cnt_reg <= cnt_nx;
                    end else if (dd) begin
                        write_byte_out <= `FDSQ_B_SYNC;
                        write_missing_clock_out <= 1'b1;
                        cnt_reg <= `FDSQ_CNT_ONE;
                        state_reg <= S_WSYNC;
                    end else begin
                        emit_mark;
                    end
                end
            end
            S_WSYNC: begin
                if (disk_byte_stb) begin
                    if (cnt_reg == `FDSQ_SYNC_N) begin
                        emit_mark;
                        write_missing_clock_out <= 1'b0;
                    end else begin
                        write_byte_out <= `FDSQ_B_SYNC;
                        cnt_reg <= cnt_nx;
                    end
                end
            end
            S_WDATA: begin
                if (disk_byte_stb) begin
                    write_missing_clock_out <= 1'b0;
                    write_byte_out <= wr_byte;
                    crc_reg <= crc_byte(crc_reg, wr_byte);
                    if (!svc) begin
                        lost_reg <= 1'b1;
                    end
                    if (cnt_nx == len_reg) begin
                        byte_request <= 1'b0;
                        cnt_reg <= `FDSQ_CNT_ZERO;
                        state_reg <= S_WCRC;
                    end else begin
                        byte_request <= 1'b1;
                        cnt_reg <= cnt_nx;
                    end
                end
            end
            S_WCRC: begin
                if (disk_byte_stb) begin
                    if (cnt_reg == `FDSQ_CNT_ZERO) begin
                        write_byte_out <= crc_reg[15:8];
                        cnt_reg <= cnt_nx;
                    end else begin
                        write_byte_out <= crc_reg[7:0];
                        cnt_reg <= `FDSQ_CNT_ZERO;
                        state_reg <= S_WFF;
                    end
                end
            end
            S_WFF: begin
                if (disk_byte_stb) begin
                    if (cnt_reg == `FDSQ_CNT_ZERO) begin
                        write_byte_out <= `FDSQ_B_FILL;
                        cnt_reg <= cnt_nx;
                    end else begin
                        write_gate_out <= 1'b0;
                        sec_done;
                    end
                end
            end
            default: state_reg <= S_IDLE;
        endcase
        // abort ends a running command with an interrupt
        if (wr_abort && busy_reg) begin
            end_cmd;
        end
    end
end

endmodule

// [src/fdsq_defines.vh]
// Purpose: shared constants of the sector sequencer
// Assumes: included by the design files only
// Notes: byte counts are 11 bits wide to match the byte counter
`ifndef FDSQ_DEFINES_VH
`define FDSQ_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FDSQ_A_CMD 8'h00
`define FDSQ_A_TRK 8'h04
`define FDSQ_A_SEC 8'h08
`define FDSQ_A_DATA 8'h0C
`define FDSQ_A_STAT 8'h10
`define FDSQ_A_SPT 8'h14
`define FDSQ_A_ABORT 8'h18
// ----------------------------------------
// command bits
// ----------------------------------------
`define FDSQ_C_DEL 0
`define FDSQ_C_SIDE 1
`define FDSQ_C_SETTLE 2
`define FDSQ_C_SCMP 3
`define FDSQ_C_MULTI 4
`define FDSQ_C_WRITE 5
`define FDSQ_C_SIZE 6
`define FDSQ_C_DDEN 7
// ----------------------------------------
// status bits
// ----------------------------------------
`define FDSQ_S_BUSY 0
`define FDSQ_S_DRQ 1
`define FDSQ_S_LOST 2
`define FDSQ_S_RNF 3
`define FDSQ_S_CRC 4
`define FDSQ_S_DEL 5
// ----------------------------------------
// timing and counts
// ----------------------------------------
`define FDSQ_SETTLE_MS 24'h00001E
`define FDSQ_CLK_KHZ 24'h0061A8
`define FDSQ_REVS_ID 4'h4
`define FDSQ_REVS_SIDE 4'h5
`define FDSQ_IDLE_IDX 4'hF
`define FDSQ_DAM_SD 11'h01E
`define FDSQ_DAM_DD 11'h02B
`define FDSQ_GAP_SD 11'h00B
`define FDSQ_GAP_DD 11'h016
`define FDSQ_ZERO_SD 11'h006
`define FDSQ_ZERO_DD 11'h00C
`define FDSQ_SYNC_N 11'h003
`define FDSQ_ID_LAST 11'h005
`define FDSQ_CNT_ZERO 11'h000
`define FDSQ_CNT_ONE 11'h001
`define FDSQ_LEN_BASE 11'h080
`define FDSQ_LEN_ALT 11'h100
`define FDSQ_ID_TRK 3'h0
`define FDSQ_ID_SIDE 3'h1
`define FDSQ_ID_SEC 3'h2
`define FDSQ_ID_LEN 3'h3
// ----------------------------------------
// mark bytes and crc
// ----------------------------------------
`define FDSQ_B_SYNC 8'hA1
`define FDSQ_B_ID_ADDRESS_MARK 8'hFE
`define FDSQ_B_DAM 8'hFB
`define FDSQ_B_DDAM 8'hF8
`define FDSQ_B_ZERO 8'h00
`define FDSQ_B_FILL 8'hFF
`define FDSQ_CRC_INIT 16'hFFFF
`define FDSQ_CRC_POLY 16'h1021
`define FDSQ_CRC_GOOD 16'h0000
`endif

// [testbench/fdsq_seq_props.sv]
// Purpose: port checks for fdsq_seq
// Assumes: one clock, async low reset
// Notes: gate moves only on byte strobes, except on an abort, which drops it at once
`timescale 1ns/1ps
module fdsq_seq_props (
    // bus
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // drive
    input wire disk_byte_stb,
    input wire head_load_out,
    input wire write_gate_out,
    input wire [7:0] write_byte_out,
    input wire write_missing_clock_out,
    input wire irq_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rdy_pulse: assert property (pready |=> !pready) else $error("pready long");
    a_rdy_wait: assert property (psel && $rose(penable) |=> pready) else $error("pready late");
    a_err_rdy: assert property (pslverr |-> pready && penable) else $error("stray pslverr");
    a_gate_step: assert property ($changed(write_gate_out) |-> $past(disk_byte_stb))
        else $error("gate off strobe");
    a_gate_zero: assert property ($rose(write_gate_out) |-> write_byte_out == 8'h00)
        else $error("first byte not zero");
    a_gate_head: assert property (write_gate_out |-> head_load_out)
        else $error("gate without head");
    a_sync_gated: assert property (write_missing_clock_out |-> write_gate_out)
        else $error("mark outside gate");
    a_end_irq: assert property ($fell(write_gate_out) |-> ##[0:8] irq_out)
        else $error("no irq after gate");
    cover property ($rose(write_gate_out));
    cover property ($rose(irq_out));
    cover property (pslverr);
endmodule
bind fdsq_seq fdsq_seq_props u_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .disk_byte_stb, .head_load_out, .write_gate_out, .write_byte_out,
    .write_missing_clock_out, .irq_out);

// [testbench/fdsq_disk.sv]
// Purpose: drive model, marks and byte stream
// Assumes: tasks called right after a clock edge
// Notes: twelve clocks per byte leaves the host time
`timescale 1ns/1ps
module fdsq_disk (
    // clock and head
    input wire pclk,
    input wire head_load_out,
    // stream
    output logic disk_byte_stb = 1'b0,
    output logic [7:0] disk_byte_in = 8'h00,
    output logic id_mark_in = 1'b0,
    output logic data_mark_in = 1'b0,
    output logic deleted_mark_in = 1'b0,
    output logic index_in = 1'b0,
    output logic head_engaged_in = 1'b0
);
    logic [15:0] crc = 16'hFFFF;
    // engage held high while loaded, rising five clocks after load
    always @(posedge pclk)
        head_engaged_in <= head_load_out && $past(head_load_out, 4);
    function automatic [15:0] step(input [15:0] c, input [7:0] b);
        step = c;
        for (int i = 7; i >= 0; i--)
            step = {step[14:0], 1'b0} ^ ((step[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    endfunction
    task automatic mark(input [7:0] m);
        repeat (11) @(posedge pclk);
        id_mark_in <= (m == 8'hFE);
        data_mark_in <= (m != 8'hFE);
        deleted_mark_in <= (m == 8'hF8);
        @(posedge pclk);
        id_mark_in <= 1'b0;
        data_mark_in <= 1'b0;
        deleted_mark_in <= (m != 8'hF8);
        crc = step(16'hFFFF, m);
    endtask
    task automatic put(input [7:0] b);
        repeat (11) @(posedge pclk);
        disk_byte_stb <= 1'b1;
        disk_byte_in <= b;
        @(posedge pclk);
        disk_byte_stb <= 1'b0;
        disk_byte_in <= ~b;
        crc = step(crc, b);
    endtask
    task automatic fcs(input bad);
        logic [15:0] c;
        c = crc ^ {15'h0, bad};
        put(c[15:8]);
        put(c[7:0]);
    endtask
    task automatic id(input [7:0] t, input [7:0] sd, input [7:0] n, input bad);
        mark(8'hFE);
        put(t);
        put(sd);
        put(n);
        put(8'h00);
        fcs(bad);
    endtask
    task automatic index;
        index_in <= 1'b1;
        @(posedge pclk);
        index_in <= 1'b0;
        repeat (99) @(posedge pclk);
    endtask
endmodule

// [testbench/disk_sector_rw_sequencer_bench.sv]
// Purpose: self-checking bench for fdsq_seq
// Assumes: single density, 128-byte sectors
// Notes: host here, drive in fdsq_disk
`timescale 1ns/1ps
module disk_sector_rw_sequencer_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00, disk_byte_in, write_byte_out, q[$];
    logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'hb92f5f25;
    logic disk_byte_stb, id_mark_in, data_mark_in, deleted_mark_in, index_in, head_engaged_in;
    logic head_load_out, side_select_out, write_gate_out, write_missing_clock_out;
    logic byte_request, irq_out;
    int fails = 0, total_checks = 0;
    int wn = 0, zn = 0;
    fdsq_seq #(.SETTLE_CYCLES(24'd20)) u_dut (.*);
    fdsq_disk u_disk (.*);
    initial forever #20 pclk = ~pclk;
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic test_done;
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input [31:0] got, input [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // byte of the slot just ended: zeros, mark, host bytes in order, ones; the two crc bytes are not checked
    always @(posedge pclk) begin
        if (disk_byte_stb && write_gate_out) begin
            if (write_missing_clock_out) begin
                chk(write_byte_out, 8'hFB);
                chk(zn, 6);
            end else if (wn == 0) begin
                chk(write_byte_out, 8'h00);
                zn++;
            end else if (wn <= 128)
                chk(write_byte_out, q.pop_front());
            else if (wn == 131)
                chk(write_byte_out, 8'hFF);
            wn = (write_missing_clock_out || wn > 0) ? wn + 1 : 0;
        end
    end
    task automatic tmo(input int n);
        if (n >= 30000) begin
            fails++;
            $display("Error %0t: timeout", $time);
            test_done;
        end
    endtask
    task automatic apb(input w, input [7:0] a, input [7:0] d);
        int n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 30000);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
        tmo(n);
    endtask
    task automatic till(ref logic s);
        int n = 0;
        while (s !== 1'b1 && n < 30000) begin
            @(posedge pclk);
            n++;
        end
        tmo(n);
    endtask
    task automatic sector(input [7:0] s, input [7:0] cmd, input del, input bad, input [7:0] st);
        apb(1, 8'h08, s);
        apb(1, 8'h00, cmd);
        fork
            begin
                repeat (40) @(posedge pclk);
                u_disk.id(5, 0, 4, 0);
                u_disk.id(4, 0, s, 0);
                u_disk.id(5, 0, s, 1);
                u_disk.id(5, 0, s, 0);
                if (cmd[5])
                    repeat (170) u_disk.put(8'h4E);
                else begin
                    u_disk.mark(del ? 8'hF8 : 8'hFB);
                    repeat (128) begin
                        rnd = lfsr(rnd);
                        q.push_back(rnd[7:0]);
                        u_disk.put(rnd[7:0]);
                    end
                    u_disk.fcs(bad);
                end
            end
            repeat (128) begin
                till(byte_request);
                if (cmd[5]) begin
                    rnd = lfsr(rnd);
                    q.push_back(rnd[7:0]);
                end
                apb(cmd[5], 8'h0C, rnd[7:0]);
                if (!cmd[5])
                    chk(rd, q.pop_front());
            end
        join
        till(irq_out);
        apb(0, 8'h10, 0);
        chk(rd, st);
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(1, 8'h14, 9);
        apb(1, 8'h04, 5);
        apb(0, 8'h1C, 0);
        chk({31'h0, err}, 1);
        chk(rd, 0);
        sector(3, 8'h44, 1, 0, 8'h20);
        chk({31'h0, head_load_out}, 1);
        sector(9, 8'h54, 0, 1, 8'h10);
        sector(9, 8'h50, 0, 0, 8'h08);
        apb(0, 8'h08, 0);
        chk(rd, 10);
        sector(3, 8'h64, 0, 0, 8'h00);
        apb(1, 8'h08, 3);
        apb(1, 8'h00, 8'h0A);
        repeat (40) @(posedge pclk);
        u_disk.id(5, 0, 3, 0);
        repeat (4) u_disk.index;
        chk({31'h0, irq_out}, 0);
        u_disk.index;
        till(irq_out);
        chk({31'h0, side_select_out}, 1);
        apb(0, 8'h10, 0);
        chk(rd, 8'h08);
        test_done;
    end
endmodule
